// file: logic/fdc_ctrl.sv
// Flexible disk drive control: APB parameter registers and drive sequencer.
// Assumes an APB master on pclk and drive pins synchronous to pclk.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module fdc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin34_in,
  output logic motor_on,
  output logic step_out,
  output logic step_dir,
  output logic head_load,
  output logic precomp_en,
  output logic [7:0] precomp_amount,
  output logic reduced_current,
  output logic [15:0] rate_kbps,
  output logic pin4_out,
  output logic pin4_oe_n,
  output logic pin1_out,
  output logic pin1_oe_n
);
  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Replaces a zero field with the device default.
  function automatic logic [15:0] or_def(input logic [15:0] v, input logic [15:0] d);
    or_def = (v == 16'h0000) ? d : v;
  endfunction

  // Drives a line level from its active state and polarity bit.
  function automatic logic line_lvl(input logic act, input logic pol);
    line_lvl = pol ? act : !act;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [15:0] xfer_rate, cylinders, pc_start, rwc_start, step_rate, settle;
  logic [7:0] heads, spt, pulse_us, mon_delay, moff_delay, wcomp;
  logic [7:0] load_ms, unload_ms, pin34_fn, pin4_fn, pin1_fn;
  logic true_ready_present, sector_origin_one, motor_hold_released;
  logic [3:0] extra_steps_per_cylinder;
  logic [15:0] target_cyl, cur_cyl, sector_idx;
  logic [19:0] steps_left;
  logic run_cmd, eject_act, dcr_act, disk_changed, abort_flag, done_flag;
  fdc_pkg::fdc_state_t state;

  logic wr_en, rd_setup, cmd_wr;
  logic tick_us, tick_unit, tick_ms, tick_tenth;
  logic seq_start, seq_exp, off_start, off_exp;
  logic [15:0] seq_count;
  logic seq_tick, drive_ready, p34_act;

  // A write lands at the edge that completes the access phase.
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;
  assign cmd_wr = wr_en && (paddr == fdc_pkg::A_CMD);

  //////////////////////////////////////////////////////////////////////////////
  // APB answer: pready rises in the access phase, so there are no wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_setup;
      pslverr <= 1'b0;
      if (rd_setup) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          fdc_pkg::A_RATE: prdata <= {8'h00, heads, xfer_rate};
          fdc_pkg::A_GEOM: prdata <= {8'h00, spt, cylinders};
          fdc_pkg::A_WSTART: prdata <= {rwc_start, pc_start};
          fdc_pkg::A_STEP: prdata <= {8'h00, pulse_us, step_rate};
          fdc_pkg::A_MOTOR: prdata <= {moff_delay, mon_delay, settle};
          fdc_pkg::A_FLAGS: prdata <= {8'h00, wcomp, 4'h0, extra_steps_per_cylinder,
            true_ready_present, sector_origin_one, motor_hold_released, 5'h00};
          fdc_pkg::A_HEAD: prdata <= {pin4_fn, pin34_fn, unload_ms, load_ms};
          fdc_pkg::A_PIN1: prdata <= {fdc_pkg::ROT_RPM, 8'h00, pin1_fn};
          fdc_pkg::A_CMD: prdata <= {target_cyl, 16'h0000};
          fdc_pkg::A_STAT: prdata <= {cur_cyl, 5'h00, fdc_pkg::SAVEABLE, disk_changed,
            abort_flag, done_flag, drive_ready, run_cmd, motor_on, 1'b0, state};
          fdc_pkg::A_SECT: prdata <= {16'h0000, sector_idx + {15'h0000, sector_origin_one}};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Parameter writes; the page layout is spread over word registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_rate <= 16'h0000; heads <= 8'h00; spt <= 8'h00; cylinders <= 16'h0000;
      pc_start <= 16'h0000; rwc_start <= 16'h0000; step_rate <= 16'h0000;
      pulse_us <= 8'h00; settle <= 16'h0000; mon_delay <= 8'h00; moff_delay <= 8'h00;
      wcomp <= 8'h00; extra_steps_per_cylinder <= 4'h0; true_ready_present <= 1'b0;
      sector_origin_one <= 1'b0; motor_hold_released <= 1'b0; load_ms <= 8'h00;
      unload_ms <= 8'h00; pin34_fn <= 8'h00; pin4_fn <= 8'h00; pin1_fn <= 8'h00;
      sector_idx <= 16'h0000;
    end else if (wr_en) begin
      case (paddr)
        fdc_pkg::A_RATE: {heads, xfer_rate} <= pwdata[23:0];
        fdc_pkg::A_GEOM: {spt, cylinders} <= pwdata[23:0];
        fdc_pkg::A_WSTART: {rwc_start, pc_start} <= pwdata;
        fdc_pkg::A_STEP: {pulse_us, step_rate} <= pwdata[23:0];
        fdc_pkg::A_MOTOR: {moff_delay, mon_delay, settle} <= pwdata;
        fdc_pkg::A_FLAGS: begin
          wcomp <= pwdata[23:16];
          extra_steps_per_cylinder <= pwdata[11:8];
          true_ready_present <= pwdata[fdc_pkg::F_TRUE_READY];
          sector_origin_one <= pwdata[fdc_pkg::F_ORIGIN_ONE];
          motor_hold_released <= pwdata[fdc_pkg::F_MOH];
        end
        fdc_pkg::A_HEAD: {pin4_fn, pin34_fn, unload_ms, load_ms} <= pwdata;
        fdc_pkg::A_PIN1: pin1_fn <= pwdata[7:0];
        fdc_pkg::A_SECT: sector_idx <= pwdata[15:0];
        default: sector_idx <= sector_idx;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Drive line inputs.

  assign p34_act = line_lvl(pin34_in, pin34_fn[fdc_pkg::PF_POL]);
  assign drive_ready = (pin34_fn[6:4] == fdc_pkg::FN_P34_READY) && p34_act;

  // Sticky flags; a new event wins over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disk_changed <= 1'b0;
    end else if ((pin34_fn[6:4] == fdc_pkg::FN_P34_CHANGED) && p34_act) begin
      disk_changed <= 1'b1;
    end else if (cmd_wr && pwdata[fdc_pkg::C_CLR]) begin
      disk_changed <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Time base and timers.
  fdc_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick_us(tick_us),
    .tick_unit(tick_unit),
    .tick_ms(tick_ms),
    .tick_tenth(tick_tenth)
  );

  fdc_timer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(seq_start),
    .count(seq_count),
    .tick(seq_tick),
    .expired(seq_exp)
  );

  fdc_timer u_off (
    .pclk(pclk),
    .presetn(presetn),
    .start(off_start),
    .count({8'h00, moff_delay}),
    .tick(tick_tenth),
    .expired(off_exp)
  );

  // Timer load picks unit and count for the state being entered.
  always_comb begin
    seq_start = 1'b0;
    seq_count = 16'h0000;
    seq_tick = tick_unit;
    case (state)
      fdc_pkg::ST_SPIN, fdc_pkg::ST_READY: seq_tick = tick_tenth;
      fdc_pkg::ST_STEP_HI: seq_tick = tick_us;
      fdc_pkg::ST_LOAD, fdc_pkg::ST_UNLOAD: seq_tick = tick_ms;
      default: seq_tick = tick_unit;
    endcase
    if (state == fdc_pkg::ST_IDLE && cmd_wr && pwdata[fdc_pkg::C_ACCESS]) begin
      seq_start = 1'b1;
      seq_count = {8'h00, mon_delay};
    end else if (state == fdc_pkg::ST_STEP_HI && seq_exp) begin
      seq_start = 1'b1;
      seq_count = or_def(step_rate, fdc_pkg::DEF_STEP_RATE);
    end else if (state == fdc_pkg::ST_STEP_LO && seq_exp) begin
      seq_start = 1'b1;
      if (steps_left != 20'h00000) begin
        seq_count = or_def({8'h00, pulse_us}, 16'(fdc_pkg::DEF_PULSE_US));
      end else begin
        seq_count = or_def(settle, fdc_pkg::DEF_SETTLE);
      end
    end else if ((state == fdc_pkg::ST_SETTLE && seq_exp) ||
                 (state == fdc_pkg::ST_SPIN && cur_cyl == target_cyl &&
                  (seq_exp || (true_ready_present && drive_ready)))) begin
      seq_start = 1'b1;
      seq_count = or_def({8'h00, load_ms}, 16'(fdc_pkg::DEF_LOAD_MS));
    end else if (state == fdc_pkg::ST_SPIN &&
                 (seq_exp || (true_ready_present && drive_ready))) begin
      seq_start = 1'b1;
      seq_count = or_def({8'h00, pulse_us}, 16'(fdc_pkg::DEF_PULSE_US));
    end else if (state == fdc_pkg::ST_READY && cmd_wr && pwdata[fdc_pkg::C_RELEASE]) begin
      seq_start = 1'b1;
      seq_count = or_def({8'h00, unload_ms}, 16'(fdc_pkg::DEF_UNLOAD_MS));
    end
  end

  assign off_start = (state == fdc_pkg::ST_UNLOAD && seq_exp) ||
                     (seq_start && state == fdc_pkg::ST_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // Access sequencer: spin up, step, settle, load head, hold, unload.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= fdc_pkg::ST_IDLE;
      target_cyl <= 16'h0000;
      cur_cyl <= 16'h0000;
      steps_left <= 20'h00000;
      step_dir <= 1'b0;
    end else begin
      case (state)
        fdc_pkg::ST_IDLE: begin
          if (cmd_wr && pwdata[fdc_pkg::C_ACCESS]) begin
            target_cyl <= pwdata[31:16];
            state <= fdc_pkg::ST_SPIN;
          end
        end
        fdc_pkg::ST_SPIN: begin
          steps_left <= 20'((target_cyl > cur_cyl ? target_cyl - cur_cyl : cur_cyl - target_cyl)
                            * ({1'b0, extra_steps_per_cylinder} + 5'h01));
          step_dir <= target_cyl > cur_cyl;
          if (true_ready_present && drive_ready) begin
            state <= (cur_cyl == target_cyl) ? fdc_pkg::ST_LOAD : fdc_pkg::ST_STEP_HI;
          end else if (seq_exp && true_ready_present) begin
            state <= fdc_pkg::ST_IDLE;
          end else if (seq_exp) begin
            state <= (cur_cyl == target_cyl) ? fdc_pkg::ST_LOAD : fdc_pkg::ST_STEP_HI;
          end
        end
        fdc_pkg::ST_STEP_HI: begin
          if (seq_exp) begin
            steps_left <= steps_left - 20'h00001;
            state <= fdc_pkg::ST_STEP_LO;
          end
        end
        fdc_pkg::ST_STEP_LO: begin
          if (seq_exp) begin
            state <= (steps_left != 20'h00000) ? fdc_pkg::ST_STEP_HI : fdc_pkg::ST_SETTLE;
          end
        end
        fdc_pkg::ST_SETTLE: begin
          cur_cyl <= target_cyl;
          if (seq_exp) state <= fdc_pkg::ST_LOAD;
        end
        fdc_pkg::ST_LOAD: begin
          if (seq_exp) state <= fdc_pkg::ST_READY;
        end
        fdc_pkg::ST_READY: begin
          if (cmd_wr && pwdata[fdc_pkg::C_RELEASE]) state <= fdc_pkg::ST_UNLOAD;
        end
        fdc_pkg::ST_UNLOAD: begin
          if (seq_exp) state <= fdc_pkg::ST_IDLE;
        end
        default: state <= fdc_pkg::ST_IDLE;
      endcase
    end
  end

  // Done and abort are sticky; the hardware set wins over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
      abort_flag <= 1'b0;
    end else begin
      if (state == fdc_pkg::ST_LOAD && seq_exp) done_flag <= 1'b1;
      else if (cmd_wr && pwdata[fdc_pkg::C_CLR]) done_flag <= 1'b0;
      if (state == fdc_pkg::ST_SPIN && seq_exp && true_ready_present && !drive_ready)
        abort_flag <= 1'b1;
      else if (cmd_wr && pwdata[fdc_pkg::C_CLR]) abort_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Motor control. Start commands, and stop commands given in idle, bypass the idle delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cmd <= 1'b0;
      motor_on <= 1'b0;
    end else begin
      if (cmd_wr && pwdata[fdc_pkg::C_START]) run_cmd <= 1'b1;
      else if (cmd_wr && pwdata[fdc_pkg::C_STOP]) run_cmd <= 1'b0;
      if (motor_hold_released) motor_on <= 1'b0;
      else if (state == fdc_pkg::ST_SPIN || (cmd_wr && pwdata[fdc_pkg::C_START])) motor_on <= 1'b1;
      else if (cmd_wr && pwdata[fdc_pkg::C_STOP] && state == fdc_pkg::ST_IDLE) motor_on <= 1'b0;
      else if (state == fdc_pkg::ST_IDLE && off_exp && !run_cmd &&
               moff_delay != fdc_pkg::MOTOR_NEVER_OFF) motor_on <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Drive outputs, each from its own flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_out <= 1'b0;
      head_load <= 1'b0;
      precomp_en <= 1'b0;
      precomp_amount <= 8'h00;
      reduced_current <= 1'b0;
      rate_kbps <= 16'h0000;
    end else begin
      step_out <= (state == fdc_pkg::ST_STEP_HI) && !seq_exp;
      head_load <= (state == fdc_pkg::ST_LOAD) || (state == fdc_pkg::ST_READY);
      precomp_en <= (pc_start != cylinders) && (cur_cyl >= pc_start);
      precomp_amount <= 8'(or_def({8'h00, wcomp}, 16'(fdc_pkg::DEF_WCOMP)));
      reduced_current <= (rwc_start != cylinders) && (cur_cyl >= rwc_start);
      rate_kbps <= xfer_rate;
    end
  end

  // Eject and disk change reset requests; the reset lasts until the next microsecond tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eject_act <= 1'b0;
      dcr_act <= 1'b0;
    end else begin
      if (cmd_wr && pwdata[fdc_pkg::C_EJECT]) eject_act <= 1'b1;
      else if (cmd_wr) eject_act <= 1'b0;
      if (cmd_wr && pwdata[fdc_pkg::C_DCRST]) dcr_act <= 1'b1;
      else if (tick_us) dcr_act <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin4_out <= 1'b1;
      pin4_oe_n <= 1'b1;
      pin1_out <= 1'b1;
      pin1_oe_n <= 1'b1;
    end else begin
      pin4_oe_n <= 1'b0;
      case (pin4_fn[6:4])
        fdc_pkg::FN_P4_INUSE:
          pin4_out <= line_lvl(state != fdc_pkg::ST_IDLE, pin4_fn[fdc_pkg::PF_POL]);
        fdc_pkg::FN_P4_EJECT: pin4_out <= line_lvl(eject_act, pin4_fn[fdc_pkg::PF_POL]);
        fdc_pkg::FN_P4_LOAD: pin4_out <= line_lvl(head_load, pin4_fn[fdc_pkg::PF_POL]);
        default: begin
          pin4_out <= 1'b1;
          pin4_oe_n <= 1'b1;
        end
      endcase
      pin1_oe_n <= pin1_fn[6:4] != fdc_pkg::FN_P1_DCRST;
      pin1_out <= (pin1_fn[6:4] == fdc_pkg::FN_P1_DCRST) ?
                  line_lvl(dcr_act, pin1_fn[fdc_pkg::PF_POL]) : 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: logic/fdc_tick.sv
// Time base: one-cycle ticks every 1 us, 100 us, 1 ms and 100 ms.
// Assumes pclk at the rate named in the package.
`timescale 1ns/100ps
`default_nettype none
module fdc_tick (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick_us,
  output logic tick_unit,
  output logic tick_ms,
  output logic tick_tenth
);
  logic [5:0] c_cyc;
  logic [6:0] c_us;
  logic [3:0] c_unit;
  logic [6:0] c_ms;

  // Chained counters keep every stage narrow instead of one wide divider.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_cyc <= 6'h00;
      c_us <= 7'h00;
      c_unit <= 4'h0;
      c_ms <= 7'h00;
      tick_us <= 1'b0;
      tick_unit <= 1'b0;
      tick_ms <= 1'b0;
      tick_tenth <= 1'b0;
    end else begin
      tick_us <= 1'b0;
      tick_unit <= 1'b0;
      tick_ms <= 1'b0;
      tick_tenth <= 1'b0;
      c_cyc <= c_cyc + 6'h01;
      if (c_cyc == 6'(fdc_pkg::CYC_PER_US - 1)) begin
        c_cyc <= 6'h00;
        tick_us <= 1'b1;
        c_us <= c_us + 7'h01;
        if (c_us == 7'(fdc_pkg::US_PER_UNIT - 1)) begin
          c_us <= 7'h00;
          tick_unit <= 1'b1;
          c_unit <= c_unit + 4'h1;
          if (c_unit == 4'(fdc_pkg::UNIT_PER_MS - 1)) begin
            c_unit <= 4'h0;
            tick_ms <= 1'b1;
            c_ms <= c_ms + 7'h01;
            if (c_ms == 7'(fdc_pkg::MS_PER_TENTH - 1)) begin
              c_ms <= 7'h00;
              tick_tenth <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/fdc_timer.sv
// Down counter of ticks; expired rises after count ticks and holds.
// Assumes start is a one-cycle pulse; the first tick may come early by up to one unit.
`timescale 1ns/100ps
`default_nettype none
module fdc_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [15:0] count,
  input wire logic tick,
  output logic expired
);
  logic [15:0] cnt;
  logic run;

  // A restart always wins, so a pending expiry is cancelled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      run <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      cnt <= count;
      run <= 1'b1;
      expired <= 1'b0;
    end else if (run && tick) begin
      if (cnt <= 16'h0001) begin
        run <= 1'b0;
        expired <= 1'b1;
      end else begin
        cnt <= cnt - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// file: shared/fdc_pkg.sv
// Constants shared by the flexible disk drive control block.
// Assumes a 40 MHz APB clock and 32-bit APB data.
package fdc_pkg;
  // Clock and time units.
  localparam int CLK_PERIOD_NS = 25;
  localparam int US_NS = 1000;
  localparam int STEP_UNIT_US = 100;
  localparam int MS_US = 1000;
  localparam int TENTH_S_MS = 100;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int US_PER_UNIT = STEP_UNIT_US;
  localparam int UNIT_PER_MS = MS_US / STEP_UNIT_US;
  localparam int MS_PER_TENTH = TENTH_S_MS;
  // Register byte addresses.
  localparam logic [7:0] A_RATE = 8'h00;
  localparam logic [7:0] A_GEOM = 8'h04;
  localparam logic [7:0] A_WSTART = 8'h08;
  localparam logic [7:0] A_STEP = 8'h0C;
  localparam logic [7:0] A_MOTOR = 8'h10;
  localparam logic [7:0] A_FLAGS = 8'h14;
  localparam logic [7:0] A_HEAD = 8'h18;
  localparam logic [7:0] A_PIN1 = 8'h1C;
  localparam logic [7:0] A_CMD = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam logic [7:0] A_SECT = 8'h28;
  // Command bits.
  localparam int C_ACCESS = 0;
  localparam int C_RELEASE = 1;
  localparam int C_START = 2;
  localparam int C_STOP = 3;
  localparam int C_EJECT = 4;
  localparam int C_DCRST = 5;
  localparam int C_CLR = 6;
  // Flag bits.
  localparam int F_TRUE_READY = 7;
  localparam int F_ORIGIN_ONE = 6;
  localparam int F_MOH = 5;
  // Defaults used when a field is zero, and the motor off delay code for never.
  localparam logic [15:0] DEF_STEP_RATE = 16'h001E;
  localparam logic [7:0] DEF_PULSE_US = 8'h01;
  localparam logic [15:0] DEF_SETTLE = 16'h0096;
  localparam logic [7:0] DEF_WCOMP = 8'h04;
  localparam logic [7:0] DEF_LOAD_MS = 8'h1E;
  localparam logic [7:0] DEF_UNLOAD_MS = 8'h14;
  localparam logic [7:0] MOTOR_NEVER_OFF = 8'hFF;
  // Drive line function codes and field layout.
  localparam logic [2:0] FN_OPEN = 3'h0;
  localparam logic [2:0] FN_P34_READY = 3'h1;
  localparam logic [2:0] FN_P34_CHANGED = 3'h2;
  localparam logic [2:0] FN_P4_INUSE = 3'h1;
  localparam logic [2:0] FN_P4_EJECT = 3'h2;
  localparam logic [2:0] FN_P4_LOAD = 3'h3;
  localparam logic [2:0] FN_P1_DCRST = 3'h1;
  localparam int PF_POL = 7;
  // Read-only page values; rotation rate is a plain default.
  localparam logic [15:0] ROT_RPM = 16'h012C;
  localparam logic SAVEABLE = 1'b0;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SPIN = 3'b001,
    ST_STEP_HI = 3'b010,
    ST_STEP_LO = 3'b011,
    ST_SETTLE = 3'b100,
    ST_LOAD = 3'b101,
    ST_READY = 3'b110,
    ST_UNLOAD = 3'b111
  } fdc_state_t;
endpackage

// file: tb/fdc_ctrl_properties.sv
// Port checker for the drive control block.
// Assumes the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module fdc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic step_out,
  input wire logic head_load,
  input wire logic [15:0] rate_kbps
);
  // One domain, so one clock and one reset serve every property.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd = psel && penable && pready && !pwrite;
  wire logic wr = psel && penable && pready && pwrite;
  a_zero_wait: assert property (psel && !penable |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h28 |-> pslverr)
    else $error("no error");
  a_rot_fixed: assert property (rd && paddr == 8'h1C |-> prdata[31:16] == 16'h012C)
    else $error("bad rpm");
  a_save_zero: assert property (rd && paddr == 8'h24 |-> !prdata[10])
    else $error("save set");
  a_rate_copy: assert property (wr && paddr == 8'h00 |=> ##1
    rate_kbps == $past(pwdata[15:0], 2)) else $error("rate lost");
  a_settle_first: assert property ($fell(step_out) |-> !head_load [*2])
    else $error("no settle");
  c_err: cover property (rd && pslverr);
  c_step: cover property ($rose(step_out));
  c_load: cover property ($rose(head_load));
endmodule
bind fdc_ctrl fdc_props fdc_props_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .step_out, .head_load, .rate_kbps);
`default_nettype wire

// file: tb/fdc_drive_model.sv
// Drive mechanism seen from the drive lines.
// Assumes an active high motor line from the control block.
`timescale 1ns/100ps
`default_nettype none
module fdc_drive_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic motor_on,
  input wire logic ready_high,
  output logic pin34_in
);
  logic [7:0] spun;
  // ready after spin-up
  // Ready comes only once the spindle is up to speed, so gating is exercised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) spun <= 8'h00;
    else spun <= motor_on ? spun + 8'(spun < 8'h14) : 8'h00;
  end
  assign pin34_in = (spun == 8'h14) ~^ ready_high;
endmodule
`default_nettype wire

// file: tb/tb_flexible_disk_drive_control.sv
// Bench for the drive control block: register access, then one seek.
// Assumes the drive model answers on the ready line.
`timescale 1ns/100ps
`default_nettype none
module tb_flexible_disk_drive_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pin34_in, pready, pslverr, motor_on, step_out, head_load, precomp_en, reduced_current;
  logic [7:0] paddr = 8'h00, precomp_amount;
  logic [31:0] pwdata = 32'h0, prdata, rnd;
  logic [15:0] rate_kbps;
  logic step_dir, pin4_out, pin4_oe_n, pin1_out, pin1_oe_n;
  logic [32:0] expq[$];
  logic [39:0] cfg[7] = '{40'h14_0000_0180, 40'h04_0000_0050, 40'h08_0050_0001,
    40'h0C_0001_0001, 40'h10_0101_0001, 40'h18_0090_0101, 40'h20_0001_0001};
  int n_errors = 0, checked = 0, seed = 8, steps = 0, n;
  fdc_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pin34_in, .motor_on, .step_out, .step_dir, .head_load,
    .precomp_en, .precomp_amount, .reduced_current, .rate_kbps, .pin4_out,
    .pin4_oe_n, .pin1_out, .pin1_oe_n);
  fdc_drive_model drive_u (.pclk, .presetn, .motor_on, .ready_high(1'b1), .pin34_in);
  // Clock and a count of step pulses.
  initial forever #12.5 pclk = ~pclk;
  always @(posedge step_out) steps++;
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  // The request is held until pready is sampled high, or released after 64 cycles without it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (!pready && ++n < 64);
    // A slave that never answers counts as a mismatch.
    if (!pready) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads note {error, data}; the monitor takes the oldest note at pready.
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) cmp({pslverr, prdata}, expq.pop_front());
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Head load comes about 12k cycles into the seek; this stays inside the run budget.
  initial begin
    repeat (98000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end
  // Register checks first, then a seek of one cylinder with two pulses each.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rnd = $random(seed);
    apb(1'b1, 8'h00, rnd & 32'h00FF_FFFF);
    // The rate output follows the register one edge later.
    repeat (2) @(posedge pclk);
    cmp(33'(rate_kbps), 33'(rnd[15:0]));
    apb(1'b1, 8'h1C, 32'hFFFF_0000);
    rd(8'h1C, 33'h0_012C_0000);
    rd(8'h24, 33'h0);
    rd(8'h40, 33'h1_0000_0000);
    apb(1'b1, 8'h14, 32'h40);
    apb(1'b1, 8'h28, 32'h5);
    rd(8'h28, 33'h6);
    foreach (cfg[i]) apb(1'b1, cfg[i][39:32], cfg[i][31:0]);
    rd(8'h28, 33'h5);
    n = 0;
    while (!head_load && n++ < 90000) @(posedge pclk);
    if (!head_load) n_errors++;
    rd(8'h24, 33'h0_0001_0055);
    cmp(33'(steps), 33'h2);
    cmp(33'(step_dir), 33'h1);
    cmp(33'(motor_on), 33'h1);
    cmp(33'({precomp_en, reduced_current, precomp_amount}), 33'h204);
    cmp(33'({pin4_out, pin4_oe_n, pin1_out, pin1_oe_n}), 33'hF);
    // Let the monitor take the last read before the queue is judged.
    @(posedge pclk);
    if (expq.size() != 0) n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
